/* File: hdl/irq_prio_defines.svh */
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// register word offsets on the plain register port
`define LOW_VOLTAGE_IRQ_PRIORITY_OFS    4'h0
`define CHARGE_TIME_IRQ_PRIORITY_OFS    4'h1
`define UART3_IRQ_PRIORITY_OFS          4'h2
`define UART4_ERR_USB_I2C3_PRIORITY_OFS 4'h3
`define SPI3_UART4_IRQ_PRIORITY_OFS     4'h4

// field low-bit positions inside a 16-bit register
`define PRIO_FIELD_LSB_0 0
`define PRIO_FIELD_LSB_1 4
`define PRIO_FIELD_LSB_2 8
`define PRIO_FIELD_LSB_3 12

// every field resets to level 4
`define PRIO_RESET_VALUE 3'h4

// implemented-bit masks per register
`define LOW_VOLTAGE_MASK 16'h0007
`define CHARGE_TIME_MASK 16'h0070
`define UART3_MASK       16'h7770
`define UART4_USB_MASK   16'h7777
`define SPI3_UART4_MASK  16'h7777

`endif

/* File: hdl/irq_prio_pkg.sv */
package irq_prio_pkg;
  typedef logic [2:0] prio_level_t;
  typedef logic [15:0] reg_word_t;
endpackage

/* File: hdl/irq_priority_regs_upper.sv */
// Overview of operation
// - code 111 gives priority level 7
// - codes 001..110 map directly to levels
// - code 000 disables the source entirely
// - unimplemented bits ignore writes, read zero
// - low-voltage field sits in bits 2-0
// - charge-time field sits in bits 6-4
// - usb otg field at bits 10-8
// - spi3 fault field at bits 10-8
// - reset loads level 4 in every field
`include "irq_prio_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module irq_priority_regs_upper
  import irq_prio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // per-source interrupt request from flag and enable
  input  wire logic [13:0] src_pending,
  // per-source priority levels to arbitration, 0 when disabled
  output prio_level_t      low_voltage_prio,
  output prio_level_t      charge_time_prio,
  output prio_level_t      uart3_tx_prio,
  output prio_level_t      uart3_rx_prio,
  output prio_level_t      uart3_err_prio,
  output prio_level_t      uart4_err_prio,
  output prio_level_t      usb_otg_prio,
  output prio_level_t      i2c3_master_prio,
  output prio_level_t      i2c3_slave_prio,
  output prio_level_t      spi3_event_prio,
  output prio_level_t      spi3_fault_prio,
  output prio_level_t      uart4_tx_prio,
  output prio_level_t      uart4_rx_prio,
  output prio_level_t      charge_time_measurement_unit_prio,
  // gated requests toward the cpu
  output logic      [13:0] src_request
);

  // storage, only implemented bits ever become set
  reg_word_t low_voltage_irq_priority;
  reg_word_t charge_time_irq_priority;
  reg_word_t uart3_irq_priority;
  reg_word_t uart4_err_usb_i2c3_priority;
  reg_word_t spi3_uart4_irq_priority;

  // reset images built from the common field value
  localparam reg_word_t RST_ALL = {1'b0, `PRIO_RESET_VALUE, 1'b0, `PRIO_RESET_VALUE,
                                   1'b0, `PRIO_RESET_VALUE, 1'b0, `PRIO_RESET_VALUE};

  // address decode
  wire sel_lv  = (reg_addr == `LOW_VOLTAGE_IRQ_PRIORITY_OFS);
  wire sel_ct  = (reg_addr == `CHARGE_TIME_IRQ_PRIORITY_OFS);
  wire sel_u3  = (reg_addr == `UART3_IRQ_PRIORITY_OFS);
  wire sel_u4  = (reg_addr == `UART4_ERR_USB_I2C3_PRIORITY_OFS);
  wire sel_sp  = (reg_addr == `SPI3_UART4_IRQ_PRIORITY_OFS);

  // masking on write keeps unimplemented bits at zero
  wire reg_word_t wr_lv = reg_wdata & `LOW_VOLTAGE_MASK;
  wire reg_word_t wr_ct = reg_wdata & `CHARGE_TIME_MASK;
  wire reg_word_t wr_u3 = reg_wdata & `UART3_MASK;
  wire reg_word_t wr_u4 = reg_wdata & `UART4_USB_MASK;
  wire reg_word_t wr_sp = reg_wdata & `SPI3_UART4_MASK;

  // register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_voltage_irq_priority    <= RST_ALL & `LOW_VOLTAGE_MASK;
      charge_time_irq_priority    <= RST_ALL & `CHARGE_TIME_MASK;
      uart3_irq_priority          <= RST_ALL & `UART3_MASK;
      uart4_err_usb_i2c3_priority <= RST_ALL & `UART4_USB_MASK;
      spi3_uart4_irq_priority     <= RST_ALL & `SPI3_UART4_MASK;
    end else if (reg_wr) begin
      if (sel_lv) low_voltage_irq_priority    <= wr_lv;
      if (sel_ct) charge_time_irq_priority    <= wr_ct;
      if (sel_u3) uart3_irq_priority          <= wr_u3;
      if (sel_u4) uart4_err_usb_i2c3_priority <= wr_u4;
      if (sel_sp) spi3_uart4_irq_priority     <= wr_sp;
    end
  end

  // read mux; unmapped addresses read zero
  wire reg_word_t rd_mux = sel_lv ? low_voltage_irq_priority    :
                           sel_ct ? charge_time_irq_priority    :
                           sel_u3 ? uart3_irq_priority          :
                           sel_u4 ? uart4_err_usb_i2c3_priority :
                           sel_sp ? spi3_uart4_irq_priority     : 16'h0000;

  // read data registered, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // field extraction; the level is the binary code itself
  assign low_voltage_prio  = low_voltage_irq_priority[`PRIO_FIELD_LSB_0 +: 3];
  assign charge_time_prio  = charge_time_irq_priority[`PRIO_FIELD_LSB_1 +: 3];
  assign charge_time_measurement_unit_prio = charge_time_prio;
  assign uart3_tx_prio     = uart3_irq_priority[`PRIO_FIELD_LSB_3 +: 3];
  assign uart3_rx_prio     = uart3_irq_priority[`PRIO_FIELD_LSB_2 +: 3];
  assign uart3_err_prio    = uart3_irq_priority[`PRIO_FIELD_LSB_1 +: 3];
  assign uart4_err_prio    = uart4_err_usb_i2c3_priority[`PRIO_FIELD_LSB_3 +: 3];
  assign usb_otg_prio      = uart4_err_usb_i2c3_priority[`PRIO_FIELD_LSB_2 +: 3];
  assign i2c3_master_prio  = uart4_err_usb_i2c3_priority[`PRIO_FIELD_LSB_1 +: 3];
  assign i2c3_slave_prio   = uart4_err_usb_i2c3_priority[`PRIO_FIELD_LSB_0 +: 3];
  assign spi3_event_prio   = spi3_uart4_irq_priority[`PRIO_FIELD_LSB_3 +: 3];
  assign spi3_fault_prio   = spi3_uart4_irq_priority[`PRIO_FIELD_LSB_2 +: 3];
  assign uart4_tx_prio     = spi3_uart4_irq_priority[`PRIO_FIELD_LSB_1 +: 3];
  assign uart4_rx_prio     = spi3_uart4_irq_priority[`PRIO_FIELD_LSB_0 +: 3];

  // a zero level blocks the request whatever flag and enable say
  wire prio_level_t lvl [14];
  assign lvl[0]  = low_voltage_prio;
  assign lvl[1]  = charge_time_prio;
  assign lvl[2]  = uart3_tx_prio;
  assign lvl[3]  = uart3_rx_prio;
  assign lvl[4]  = uart3_err_prio;
  assign lvl[5]  = uart4_err_prio;
  assign lvl[6]  = usb_otg_prio;
  assign lvl[7]  = i2c3_master_prio;
  assign lvl[8]  = i2c3_slave_prio;
  assign lvl[9]  = spi3_event_prio;
  assign lvl[10] = spi3_fault_prio;
  assign lvl[11] = uart4_tx_prio;
  assign lvl[12] = uart4_rx_prio;
  assign lvl[13] = charge_time_prio;

  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_gate
      assign src_request[gi] = src_pending[gi] & (lvl[gi] != 3'h0);
    end
  endgenerate

endmodule // irq_priority_regs_upper

`default_nettype wire

/* File: verif/irq_prio_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_chk import irq_prio_pkg::*; (
  // register port and sources
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [13:0] src_pending,
  input wire logic [13:0] src_request,
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // levels
  input wire prio_level_t low_voltage_prio,
  input wire prio_level_t charge_time_prio,
  input wire prio_level_t usb_otg_prio,
  input wire prio_level_t spi3_fault_prio
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a level follows its write one edge later
  a_lowv_field: assert property (reg_wr && reg_addr == 4'h0
    |=> low_voltage_prio == $past(reg_wdata[2:0])) else $error("lowv field");
  a_ctime_field: assert property (reg_wr && reg_addr == 4'h1
    |=> charge_time_prio == $past(reg_wdata[6:4])) else $error("ctime field");
  a_usb_field: assert property (reg_wr && reg_addr == 4'h3
    |=> usb_otg_prio == $past(reg_wdata[10:8])) else $error("usb field");
  a_spi_fault: assert property (reg_wr && reg_addr == 4'h4
    |=> spi3_fault_prio == $past(reg_wdata[10:8])) else $error("spi fault field");
  a_reset_four: assert property ($fell(sys_rst) |-> usb_otg_prio == 3'h4
    && low_voltage_prio == 3'h4) else $error("reset level");
  // level 0 masks the request, any other level passes it
  a_gate_level: assert property (src_request[6] == (src_pending[6] && |usb_otg_prio))
    else $error("request gating");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("rdata idle");
  a_read_mask: assert property ($past(reg_rd) |-> (reg_rdata & 16'h8888) == 16'h0000)
    else $error("unused bits");
endmodule // irq_prio_chk
bind irq_priority_regs_upper irq_prio_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .src_pending, .src_request, .low_voltage_prio,
  .charge_time_prio, .usb_otg_prio, .spi3_fault_prio);
`default_nettype wire

/* File: verif/irq_priority_regs_upper_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module irq_priority_regs_upper_tb_top;
  import irq_prio_pkg::*;
  // source index to register and field position
  localparam int RI[14] = '{0, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 1};
  localparam int LS[14] = '{0, 4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0, 4};
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0;
  reg_word_t   reg_wdata = 16'h0000, reg_rdata, m[5];
  logic [13:0] src_pending = 14'h0000, src_request;
  int          error_cnt = 0, checks_done = 0;
  // every level output, index 14 is the second charge-time copy
  prio_level_t lv[15];
  always #25 clk = ~clk;
  irq_priority_regs_upper u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_pending, .src_request, .low_voltage_prio(lv[0]),
    .charge_time_prio(lv[1]), .uart3_tx_prio(lv[2]), .uart3_rx_prio(lv[3]),
    .uart3_err_prio(lv[4]), .uart4_err_prio(lv[5]), .usb_otg_prio(lv[6]),
    .i2c3_master_prio(lv[7]), .i2c3_slave_prio(lv[8]), .spi3_event_prio(lv[9]),
    .spi3_fault_prio(lv[10]), .uart4_tx_prio(lv[11]), .uart4_rx_prio(lv[12]),
    .charge_time_measurement_unit_prio(lv[14]));
  function automatic reg_word_t msk(int a);
    return a == 0 ? `LOW_VOLTAGE_MASK : a == 1 ? `CHARGE_TIME_MASK : a == 2 ? `UART3_MASK :
      a == 3 ? `UART4_USB_MASK : a == 4 ? `SPI3_UART4_MASK : 16'h0000;
  endfunction
  // request passes only where the model's level is nonzero
  function automatic logic [13:0] xreq(logic [13:0] p);
    logic [13:0] r;
    for (int i = 0; i < 14; i++) r[i] = p[i] && ((m[RI[i]] >> LS[i]) & 16'h0007) != 16'h0000;
    return r;
  endfunction
  task automatic wr(int a, reg_word_t d);
    @(posedge clk);
    reg_addr <= 4'(a);
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 5) m[a] = d & msk(a);
  endtask
  task automatic rd(int a);
    @(posedge clk);
    reg_addr <= 4'(a);
    reg_rd <= 1'b1;
    src_pending <= 14'($urandom);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("rdata", (a < 5 ? m[a] : 16'h0000), reg_rdata)
    `CHK("request", xreq(src_pending), src_request)
    // each level output against its field in the model, index 13 is a duplicate
    for (int i = 0; i < 13; i++)
      `CHK("level", 3'((m[RI[i]] >> LS[i]) & 16'h0007), lv[i])
    `CHK("charge_time_measurement_unit level", 3'((m[1] >> 4) & 16'h0007), lv[14])
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // corner words all-ones and all-zero mixed with random ones, address 5 unmapped
  initial begin
    void'($urandom(32'h2771));
    for (int a = 0; a < 5; a++) m[a] = msk(a) & 16'h4444;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a);
    for (int i = 0; i < 60; i++) begin
      wr(i % 6, i % 3 == 0 ? 16'hFFFF : i % 3 == 1 ? 16'h0000 : 16'($urandom));
      rd($urandom % 6);
      rd(i % 6);
    end
    end_of_test();
  end
  // about 400 cycles expected, ten times that allowed
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule // irq_priority_regs_upper_tb_top
`default_nettype wire
